// ===== ils_pkg.sv
package ils_pkg;
  // core clock
  localparam int unsigned CLK_HZ = 25_000_000;
  // green/yellow blink rate and its half period
  localparam int unsigned BLINK_HZ = 1;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  // warning escalation time
  localparam int unsigned WARN_MIN = 30;
  localparam longint unsigned WARN_CYC = longint'(WARN_MIN) * 60 * longint'(CLK_HZ);
  // red flash timing, pause kept well above the gap so groups read apart
  localparam int unsigned PULSE_MS = 200;
  localparam int unsigned GAP_MS = 200;
  localparam int unsigned PAUSE_MS = 1200;
  localparam int unsigned PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned GAP_CYC = GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1000);
  // red flash codes
  localparam logic [2:0] CODE_OFF = 3'h0;
  localparam logic [2:0] CODE_ACT = 3'h5;
  localparam logic [2:0] CODE_HANDLE = 3'h6;
  localparam logic [2:0] CODE_CONT = 3'h7;
  // counter widths
  localparam int unsigned BLINK_W = 24;
  localparam int unsigned WARN_W = 36;
  localparam int unsigned FL_W = 32;
  // flash sequencer states
  typedef enum logic [3:0] {
    FL_IDLE = 4'h1,
    FL_ON = 4'h2,
    FL_GAP = 4'h4,
    FL_PAUSE = 4'h8
  } ils_fl_state_t;
endpackage

// ===== ils_flash.sv
`timescale 1ns/10ps
module ils_flash import ils_pkg::*; #(
  parameter int unsigned ON_CYC = PULSE_CYC,
  parameter int unsigned OFF_CYC = GAP_CYC,
  parameter int unsigned REST_CYC = PAUSE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // requested code and lamp
  input wire logic [2:0] code,
  output logic led
);
  ils_fl_state_t st_r, st_nxt;
  logic [FL_W-1:0] tmr_r, tmr_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] code_r, code_nxt;
  logic led_nxt;
  wire logic run = (code != CODE_OFF) && (code != CODE_CONT);
  wire logic on_done = tmr_r == FL_W'(ON_CYC - 1);
  wire logic gap_done = tmr_r == FL_W'(OFF_CYC - 1);
  wire logic rest_done = tmr_r == FL_W'(REST_CYC - 1);

  // pulse group sequencer, repeats the group after a long pause
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r + FL_W'(1);
    cnt_nxt = cnt_r;
    code_nxt = code_r;
    unique case (st_r)
      FL_IDLE: begin
        tmr_nxt = '0;
        if (run) begin
          st_nxt = FL_ON;
          cnt_nxt = 3'h1;
          code_nxt = code;
        end
      end
      FL_ON: begin
        if (on_done) begin
          tmr_nxt = '0;
          st_nxt = (cnt_r == code_r) ? FL_PAUSE : FL_GAP; // RULE_16
        end
      end
      FL_GAP: begin
        if (gap_done) begin
          tmr_nxt = '0;
          cnt_nxt = cnt_r + 3'h1;
          st_nxt = FL_ON;
        end
      end
      FL_PAUSE: begin
        if (rest_done) begin
          tmr_nxt = '0;
          st_nxt = FL_IDLE;
        end
      end
      default: begin
        st_nxt = FL_IDLE;
      end
    endcase
    // a vanished code stops at once instead of finishing the group
    if (!run) begin
      st_nxt = FL_IDLE;
      tmr_nxt = '0;
    end
  end

  assign led_nxt = (code == CODE_CONT) || (st_nxt == FL_ON); // RULE_15

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= FL_IDLE;
      tmr_r <= '0;
      cnt_r <= 3'h0;
      code_r <= CODE_OFF;
      led <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      cnt_r <= cnt_nxt;
      code_r <= code_nxt;
      led <= led_nxt;
    end
  end

  a_pause_dark: assert property (@(posedge core_clk) disable iff (rst) // RULE_16
    st_r == FL_PAUSE && code != CODE_CONT |-> !led)
    else $error("red lamp lit during group pause");

  a_pulse_count: assert property (@(posedge core_clk) disable iff (rst) // RULE_12
    st_r == FL_ON |-> cnt_r <= code_r && cnt_r != 3'h0)
    else $error("pulse count outside group");
endmodule

// ===== ils_core.sv
`timescale 1ns/10ps
// What this block does
// RULE_01: power-to-unlock: command high releases the lock, low keeps it locked.
// RULE_02: power-to-lock: command high engages the lock, low releases it.
// RULE_03: lock-monitoring variant: outputs on only when guard closed and locked.
// RULE_04: lock-monitoring: relocking with actuator still inserted re-enables outputs, no opening.
// RULE_05: guard-monitoring variant: outputs drop only when the guard opens.
// RULE_06: green shows supply, yellow the operating state, red error flash codes.
// RULE_07: chain inputs absent: green blinks 1 Hz, red off, yellow by guard state.
// RULE_08: internal error drops outputs; clears only after fix plus guard open and close.
// RULE_09: warning drops diagnostic output, keeps safety outputs; clears itself when cause leaves.
// RULE_10: warning lasting 30 minutes also drops both safety outputs with its code.
// RULE_11: diagnostic output high when closed and lockable or locked, low otherwise.
// RULE_12: warning codes: 1 output one, 2 output two, 3 cross short, 4 heat.
// RULE_13: output error on failed self-test or voltage on a disabled output.
// RULE_14: actuator fault gives five red pulses and immediate switch-off.
// RULE_15: handle off position gives six pulses; device defect steady red; both immediate.
// RULE_16: pulse groups repeat with a pause longer than the gap between pulses.
module ils_core import ils_pkg::*; #(
  parameter int unsigned HALF_BLINK = BLINK_HALF_CYC,
  parameter longint unsigned WARN_LIMIT = WARN_CYC,
  parameter int unsigned FL_ON = PULSE_CYC,
  parameter int unsigned FL_OFF = GAP_CYC,
  parameter int unsigned FL_REST = PAUSE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // configuration straps
  input wire logic lock_on_power,
  input wire logic guard_variant,
  // lock command and chained safety inputs
  input wire logic lock_cmd,
  input wire logic chain_input_one,
  input wire logic chain_input_two,
  // guard, actuator and handle sensing
  input wire logic guard_closed,
  input wire logic bolt_locked,
  input wire logic lock_possible,
  input wire logic handle_ok,
  input wire logic actuator_fault,
  input wire logic device_defect,
  // output and environment monitors
  input wire logic out1_test_fail,
  input wire logic out1_volt_sense,
  input wire logic out2_test_fail,
  input wire logic out2_volt_sense,
  input wire logic cross_short,
  input wire logic over_temp,
  // solenoid drive
  output logic lock_release,
  // safety and diagnostic outputs
  output logic safe_output_one,
  output logic safe_output_two,
  output logic diag_out,
  // indicators
  output logic led_green,
  output logic led_yellow,
  output logic led_red
);
  // lowest set warning gives its flash count
  function automatic logic [2:0] warn_code(input logic [3:0] w);
    logic [2:0] c;
    c = CODE_OFF;
    for (int i = 3; i >= 0; i--) begin
      if (w[i]) begin
        c = 3'(i + 1);
      end
    end
    return c;
  endfunction

  logic [BLINK_W-1:0] blink_cnt_r, blink_cnt_nxt;
  logic blink_r, blink_nxt;
  logic [WARN_W-1:0] warn_tmr_r, warn_tmr_nxt;
  logic esc_r, esc_nxt;
  logic err_r, err_nxt;
  logic opened_r, opened_nxt;
  logic [2:0] err_code_r, err_code_nxt;
  logic [2:0] red_code_r, red_code_nxt;
  logic [3:0] warn_vec;
  logic green_nxt, yellow_nxt, diag_nxt, safe_nxt, release_nxt;

  // chain and lock state
  wire logic chain_ok = chain_input_one && chain_input_two;
  wire logic locked = guard_closed && bolt_locked;
  wire logic err_cause = actuator_fault || !handle_ok || device_defect;
  wire logic warn_any = |warn_vec;
  wire logic warn_full = warn_tmr_r == WARN_W'(WARN_LIMIT - 1);

  // solenoid polarity
  assign release_nxt = lock_on_power ? !lock_cmd : lock_cmd; // RULE_01 RULE_02

  // warning sources, voltage only counts while our own output is off
  assign warn_vec[0] = out1_test_fail || (out1_volt_sense && !safe_output_one); // RULE_13
  assign warn_vec[1] = out2_test_fail || (out2_volt_sense && !safe_output_two); // RULE_13
  assign warn_vec[2] = cross_short;
  assign warn_vec[3] = over_temp;

  // escalation timer, restarts whenever the warning clears
  assign warn_tmr_nxt = !warn_any ? '0 : (warn_full ? warn_tmr_r : warn_tmr_r + WARN_W'(1)); // RULE_10
  assign esc_nxt = warn_any && (esc_r || warn_full); // RULE_10

  // error latch: set wins, clear needs fix plus open then close
  assign opened_nxt = err_r && !err_cause && (opened_r || !guard_closed); // RULE_08
  assign err_nxt = err_cause || (err_r && !(opened_r && guard_closed)); // RULE_08
  assign err_code_nxt = device_defect ? CODE_CONT :
                        actuator_fault ? CODE_ACT : // RULE_14
                        !handle_ok ? CODE_HANDLE : err_code_r; // RULE_15
  // red code, hidden while the chain is open
  assign red_code_nxt = !chain_ok ? CODE_OFF : // RULE_07
                        err_r ? err_code_r :
                        warn_code(warn_vec); // RULE_12

  // enable path for both safety channels
  assign safe_nxt = chain_ok && !err_r && !err_cause && !esc_r &&
                    (guard_variant ? guard_closed : locked); // RULE_03 RULE_04 RULE_05 RULE_08

  // diagnostic output is not safety related
  assign diag_nxt = guard_closed && (lock_possible || locked) && !warn_any && !err_r; // RULE_09 RULE_11

  // blink base shared by green and yellow
  assign blink_cnt_nxt = (blink_cnt_r == BLINK_W'(HALF_BLINK - 1)) ? '0 : blink_cnt_r + BLINK_W'(1);
  assign blink_nxt = (blink_cnt_r == BLINK_W'(HALF_BLINK - 1)) ? !blink_r : blink_r;

  // lamps: green supply, yellow guard state
  assign green_nxt = chain_ok || blink_r; // RULE_06 RULE_07
  assign yellow_nxt = !err_r && guard_closed && (bolt_locked || blink_r); // RULE_06 RULE_07

  always_ff @(posedge core_clk) begin
    if (rst) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
      warn_tmr_r <= '0;
      esc_r <= 1'b0;
      err_r <= 1'b0;
      opened_r <= 1'b0;
      err_code_r <= CODE_OFF;
      red_code_r <= CODE_OFF;
    end else begin
      blink_cnt_r <= blink_cnt_nxt;
      blink_r <= blink_nxt;
      warn_tmr_r <= warn_tmr_nxt;
      esc_r <= esc_nxt;
      err_r <= err_nxt;
      opened_r <= opened_nxt;
      err_code_r <= err_code_nxt;
      red_code_r <= red_code_nxt;
    end
  end

  // outputs, all registered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_release <= 1'b0;
      safe_output_one <= 1'b0;
      safe_output_two <= 1'b0;
      diag_out <= 1'b0;
      led_green <= 1'b0;
      led_yellow <= 1'b0;
    end else begin
      lock_release <= release_nxt;
      safe_output_one <= safe_nxt;
      safe_output_two <= safe_nxt;
      diag_out <= diag_nxt;
      led_green <= green_nxt;
      led_yellow <= yellow_nxt;
    end
  end

  // red pulse groups
  ils_flash #(
    .ON_CYC(FL_ON),
    .OFF_CYC(FL_OFF),
    .REST_CYC(FL_REST)
  ) u_flash (
    .core_clk(core_clk),
    .rst(rst),
    .code(red_code_r),
    .led(led_red)
  );

  sequence s_defect_held;
    device_defect && chain_ok ##1 device_defect && chain_ok ##1 chain_ok;
  endsequence

  sequence s_err_fixed_closed;
    err_r && !err_cause && !opened_r && guard_closed;
  endsequence

  a_unlock_polarity: assert property (@(posedge core_clk) disable iff (rst) // RULE_01
    !lock_on_power |=> lock_release == $past(lock_cmd))
    else $error("release does not follow command");

  a_lock_polarity: assert property (@(posedge core_clk) disable iff (rst) // RULE_02
    lock_on_power && lock_cmd |=> !lock_release)
    else $error("lock released while commanded locked");

  a_lockmode_off: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
    !guard_variant && !bolt_locked |=> !safe_output_one && !safe_output_two)
    else $error("outputs on while unlocked");

  a_relock_enable: assert property (@(posedge core_clk) disable iff (rst) // RULE_04
    !guard_variant && guard_closed && !bolt_locked ##1
    guard_closed && bolt_locked && chain_ok && !err_r && !err_cause && !esc_r |=> safe_output_one)
    else $error("relock did not re-enable outputs");

  a_guardmode_on: assert property (@(posedge core_clk) disable iff (rst) // RULE_05
    guard_variant && guard_closed && chain_ok && !err_r && !err_cause && !esc_r
    |=> safe_output_one && safe_output_two)
    else $error("guard variant dropped outputs while closed");

  a_chain_lamps: assert property (@(posedge core_clk) disable iff (rst) // RULE_07
    !chain_ok ##1 !chain_ok |=> !led_red)
    else $error("red lit with chain open");

  a_error_holds: assert property (@(posedge core_clk) disable iff (rst) // RULE_08
    s_err_fixed_closed |=> err_r && !safe_output_one)
    else $error("error cleared without opening guard");

  a_warn_diag: assert property (@(posedge core_clk) disable iff (rst) // RULE_09
    warn_any |=> !diag_out)
    else $error("diagnostic output high during warning");

  a_escalate_off: assert property (@(posedge core_clk) disable iff (rst) // RULE_10
    esc_r |=> !safe_output_one && !safe_output_two)
    else $error("outputs on after escalation");

  a_diag_open: assert property (@(posedge core_clk) disable iff (rst) // RULE_11
    !guard_closed |=> !diag_out)
    else $error("diagnostic output high with guard open");

  // a defect at the same time outranks the actuator code
  a_actuator_off: assert property (@(posedge core_clk) disable iff (rst) // RULE_14
    actuator_fault && !device_defect |=> !safe_output_one && err_code_r == CODE_ACT)
    else $error("actuator fault not acted on");

  a_defect_steady: assert property (@(posedge core_clk) disable iff (rst) // RULE_15
    s_defect_held |=> led_red)
    else $error("device defect not steady red");

  // fixed error, guard opened, then closed again
  sequence s_err_open_close;
    err_r && !err_cause && !guard_closed ##1 !err_cause && guard_closed;
  endsequence

  a_lock_drop: assert property (@(posedge core_clk) disable iff (rst) // RULE_02
    lock_on_power && !lock_cmd |=> lock_release)
    else $error("lock kept while power-to-lock command low");

  a_lockmode_on: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
    !guard_variant && locked && chain_ok && !err_r && !err_cause && !esc_r
    |=> safe_output_one && safe_output_two)
    else $error("outputs off while closed and locked");

  a_guardmode_off: assert property (@(posedge core_clk) disable iff (rst) // RULE_05
    guard_variant && !guard_closed |=> !safe_output_one && !safe_output_two)
    else $error("guard variant outputs on with guard open");

  a_error_off: assert property (@(posedge core_clk) disable iff (rst) // RULE_08
    err_r |=> !safe_output_one && !safe_output_two)
    else $error("outputs on while error latched");

  a_error_clear: assert property (@(posedge core_clk) disable iff (rst) // RULE_08
    s_err_open_close |=> !err_r)
    else $error("error kept after fix and guard cycle");

  a_warn_keeps: assert property (@(posedge core_clk) disable iff (rst) // RULE_09
    warn_any && locked && chain_ok && !err_r && !err_cause && !esc_r
    |=> safe_output_one && safe_output_two)
    else $error("warning dropped safety outputs early");

  a_warn_reset: assert property (@(posedge core_clk) disable iff (rst) // RULE_09
    !warn_any |=> warn_tmr_r == WARN_W'(0) && !esc_r)
    else $error("warning state kept after cause left");

  a_escalate_set: assert property (@(posedge core_clk) disable iff (rst) // RULE_10
    warn_any && warn_full |=> esc_r)
    else $error("long warning not escalated");

  a_diag_ok: assert property (@(posedge core_clk) disable iff (rst) // RULE_11
    guard_closed && lock_possible && !warn_any && !err_r |=> diag_out)
    else $error("diagnostic output low while lockable");

  a_heat_code: assert property (@(posedge core_clk) disable iff (rst) // RULE_12
    chain_ok && !err_r && warn_vec == 4'h8 |=> red_code_r == 3'h4)
    else $error("overtemperature code wrong");

  a_volt_code: assert property (@(posedge core_clk) disable iff (rst) // RULE_13
    out1_volt_sense && !safe_output_one && chain_ok && !err_r |=> red_code_r == 3'h1)
    else $error("voltage on disabled output not flagged");

  a_handle_code: assert property (@(posedge core_clk) disable iff (rst) // RULE_15
    !handle_ok && !actuator_fault && !device_defect
    |=> err_r && err_code_r == CODE_HANDLE && !safe_output_one)
    else $error("handle fault not acted on");

  a_green_steady: assert property (@(posedge core_clk) disable iff (rst) // RULE_06
    chain_ok |=> led_green)
    else $error("green not steady with chain present");

  a_green_blink: assert property (@(posedge core_clk) disable iff (rst) // RULE_07
    !chain_ok |=> led_green == $past(blink_r))
    else $error("green not blinking with chain open");

  a_yellow_dark: assert property (@(posedge core_clk) disable iff (rst) // RULE_07
    !guard_closed || err_r |=> !led_yellow)
    else $error("yellow lit with guard open or error");

  a_yellow_locked: assert property (@(posedge core_clk) disable iff (rst) // RULE_07
    guard_closed && bolt_locked && !err_r |=> led_yellow)
    else $error("yellow not steady while locked");
endmodule

// ===== ils_plc_mon.sv
`timescale 1ns/10ps
module ils_plc_mon #(
  parameter int unsigned QUIET = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // lamp and outputs read back
  input wire logic led_red,
  input wire logic safe_output_one,
  input wire logic safe_output_two,
  // decoded view
  output logic [3:0] grp_r,
  output logic [7:0] grp_cnt_r,
  output logic run_ok
);
  logic [3:0] pulse_r;
  logic [7:0] dark_r;
  logic red_q_r;
  // channels count as enabled only when both agree
  assign run_ok = safe_output_one & safe_output_two;
  // pulses counted; a dark spell longer than any gap closes a group
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pulse_r <= 4'h0;
      dark_r <= 8'h00;
      red_q_r <= 1'b0;
      grp_r <= 4'h0;
      grp_cnt_r <= 8'h00;
    end else begin
      red_q_r <= led_red;
      if (led_red && !red_q_r) pulse_r <= pulse_r + 4'h1;
      if (led_red) dark_r <= 8'h00;
      else if (dark_r != 8'hFF) dark_r <= dark_r + 8'h01;
      if (!led_red && dark_r == 8'(QUIET) && pulse_r != 4'h0) begin
        grp_r <= pulse_r;
        grp_cnt_r <= grp_cnt_r + 8'h01;
        pulse_r <= 4'h0;
      end
    end
  end
endmodule

// ===== tb.sv
`timescale 1ns/10ps
module tb;
  // input vector bit positions
  localparam int LP = 0, GV = 1, LC = 2, C1 = 3, C2 = 4, GC = 5, BL = 6, PS = 7, HO = 8;
  localparam int AF = 9, DD = 10, T1 = 11, V1 = 12, T2 = 13, V2 = 14, CS = 15, OT = 16;
  int wb[4] = '{T1, T2, CS, OT};
  int eb[3] = '{AF, HO, DD};
  logic [2:0] ev = 3'h5;
  logic core_clk, rst, run_ok;
  logic [16:0] iv;
  logic lock_release, safe_output_one, safe_output_two, diag_out, led_green, led_yellow, led_red;
  logic [3:0] grp, g;
  logic [7:0] grp_cnt;
  int error_cnt, compares, n;
  // long counts shortened so groups and escalation fit the run
  ils_core #(.HALF_BLINK(4), .WARN_LIMIT(20), .FL_ON(2), .FL_OFF(2), .FL_REST(6)) i_ils_core (
    .core_clk(core_clk), .rst(rst), .lock_on_power(iv[LP]), .guard_variant(iv[GV]),
    .lock_cmd(iv[LC]), .chain_input_one(iv[C1]), .chain_input_two(iv[C2]),
    .guard_closed(iv[GC]), .bolt_locked(iv[BL]), .lock_possible(iv[PS]), .handle_ok(iv[HO]),
    .actuator_fault(iv[AF]), .device_defect(iv[DD]), .out1_test_fail(iv[T1]),
    .out1_volt_sense(iv[V1]), .out2_test_fail(iv[T2]), .out2_volt_sense(iv[V2]),
    .cross_short(iv[CS]), .over_temp(iv[OT]), .lock_release(lock_release),
    .safe_output_one(safe_output_one), .safe_output_two(safe_output_two), .diag_out(diag_out),
    .led_green(led_green), .led_yellow(led_yellow), .led_red(led_red));
  ils_plc_mon i_ils_plc_mon (.core_clk(core_clk), .rst(rst), .led_red(led_red),
    .safe_output_one(safe_output_one), .safe_output_two(safe_output_two),
    .grp_r(grp), .grp_cnt_r(grp_cnt), .run_ok(run_ok));
  // 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task put(int b, logic v);
    @(posedge core_clk);
    iv[b] <= v;
  endtask
  task wt(int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task chk(string nm, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task done(string nm);
    $display("test %s finished", nm);
  endtask
  task end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // lamp changes over 24 cycles, sel 1 yellow, 0 green
  task chg(int sel, output int m);
    logic p;
    m = 0;
    // settle past the edge that may have moved the lamp
    #1;
    p = sel ? led_yellow : led_green;
    repeat (24) begin
      wt(1);
      if ((sel ? led_yellow : led_green) !== p) m++;
      p = sel ? led_yellow : led_green;
    end
  endtask
  // second complete pulse group, so a group cut short is never read
  task grp_wait(output logic [3:0] q);
    logic [7:0] c0;
    int i;
    c0 = grp_cnt;
    i = 0;
    while (8'(grp_cnt - c0) < 8'h02 && i < 300) begin
      wt(1);
      i++;
    end
    if (i >= 300) begin
      error_cnt++;
      end_of_test;
    end
    q = grp;
  endtask
  initial begin
    error_cnt = 0;
    compares = 0;
    rst = 1'b1;
    iv = 17'h00118;
    wt(1);
    chk("rst out", safe_output_one, 8'h00);
    chk("rst green", led_green, 8'h00);
    @(posedge core_clk);
    rst <= 1'b0;
    wt(2);
    chk("green on", led_green, 8'h01);
    chk("red off", led_red, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 2; c++) begin
        put(LP, p[0]);
        put(LC, c[0]);
        wt(2);
        chk("release", lock_release, c[0] ^ p[0]);
      end
    end
    put(LP, 1'b0);
    put(LC, 1'b0);
    done("polarity");
    put(GC, 1'b1);
    put(PS, 1'b1);
    wt(2);
    chk("unlocked out", run_ok, 8'h00);
    chk("lockable diag", diag_out, 8'h01);
    chg(1, n);
    chk("yellow blink", n >= 5 && n <= 7, 8'h01);
    put(BL, 1'b1);
    wt(2);
    chk("locked out1", safe_output_one, 8'h01);
    chk("locked out2", safe_output_two, 8'h01);
    chk("yellow on", led_yellow, 8'h01);
    put(BL, 1'b0);
    wt(2);
    chk("unlock drop", run_ok, 8'h00);
    put(BL, 1'b1);
    wt(2);
    chk("relock", run_ok, 8'h01);
    put(PS, 1'b0);
    put(BL, 1'b0);
    wt(2);
    chk("no lock diag", diag_out, 8'h00);
    done("lock monitor");
    put(GV, 1'b1);
    wt(2);
    chk("closed on", run_ok, 8'h01);
    put(GC, 1'b0);
    wt(2);
    chk("open off", run_ok, 8'h00);
    chk("open diag", diag_out, 8'h00);
    put(GV, 1'b0);
    done("guard monitor");
    put(C1, 1'b0);
    chg(0, n);
    chk("green blink", n >= 5 && n <= 7, 8'h01);
    chk("chain red", led_red, 8'h00);
    chk("chain open yel", led_yellow, 8'h00);
    put(GC, 1'b1);
    put(PS, 1'b1);
    chg(1, n);
    chk("chain closed yel", n >= 5 && n <= 7, 8'h01);
    put(BL, 1'b1);
    wt(2);
    chk("chain lock yel", led_yellow, 8'h01);
    put(C1, 1'b1);
    wt(2);
    chk("chain back", run_ok, 8'h01);
    done("chain");
    foreach (wb[k]) begin
      put(wb[k], 1'b1);
      wt(3);
      chk("warn out", run_ok, 8'h01);
      chk("warn diag", diag_out, 8'h00);
      wt(25);
      chk("escalate", run_ok, 8'h00);
      grp_wait(g);
      chk("warn code", g, 8'(k + 1));
      put(wb[k], 1'b0);
      wt(4);
      chk("warn gone diag", diag_out, 8'h01);
      chk("warn gone out", run_ok, 8'h01);
    end
    put(GC, 1'b0);
    put(V1, 1'b1);
    grp_wait(g);
    chk("volt code", g, 8'h01);
    put(V1, 1'b0);
    put(GC, 1'b1);
    wt(4);
    done("warnings");
    for (int e = 0; e < 3; e++) begin
      put(eb[e], ev[e]);
      wt(2);
      chk("err out", run_ok, 8'h00);
      chk("err diag", diag_out, 8'h00);
      chk("err yellow", led_yellow, 8'h00);
      if (e < 2) begin
        grp_wait(g);
        chk("err code", g, 8'(5 + e));
      end else begin
        repeat (8) begin
          wt(1);
          chk("steady red", led_red, 8'h01);
        end
      end
      put(eb[e], ~ev[e]);
      wt(3);
      chk("err latched", run_ok, 8'h00);
      put(GC, 1'b0);
      put(GC, 1'b1);
      wt(4);
      chk("err cleared", run_ok, 8'h01);
    end
    done("errors");
    end_of_test;
  end
endmodule
